/* File: design/expanded_ram_pkg.sv */
package expanded_ram_pkg;
  // ----------------------------------------------------------------
  // auxiliary register
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_ADDR      = 8'h8E;
  localparam logic [7:0] AUX_RESET     = 8'h0C;
  localparam logic [7:0] AUX_WMASK     = 8'hAF;
  localparam int         PULLUP_BIT    = 7;
  localparam int         STRETCH_BIT   = 5;
  localparam int         SIZE_HI_BIT   = 3;
  localparam int         SIZE_LO_BIT   = 2;
  localparam int         EXTSEL_BIT    = 1;
  localparam int         LATCH_BIT     = 0;
  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOWER_TOP    = 8'h7F;
  localparam int          EXPANDED_RAM_AW      = 10;
  localparam int          IRAM_AW      = 8;
  localparam logic [15:0] EXPANDED_RAM_256     = 16'h0100;
  localparam logic [15:0] EXPANDED_RAM_512     = 16'h0200;
  localparam logic [15:0] EXPANDED_RAM_768     = 16'h0300;
  localparam logic [15:0] EXPANDED_RAM_1024    = 16'h0400;
  // ----------------------------------------------------------------
  // timing in oscillator clock periods
  // ----------------------------------------------------------------
  localparam logic [4:0] STROBE_SHORT  = 5'h06;
  localparam logic [4:0] STROBE_LONG   = 5'h1E;
  localparam logic [2:0] ALE_DIV       = 3'h6;
  localparam logic [2:0] ALE_DIV_X2    = 3'h3;
  typedef enum logic [1:0] {SEL_IRAM, SEL_AUX, SEL_SFR} idata_sel_t;
endpackage

/* File: design/ram_byte.sv */
`timescale 1ns/1ps
module ram_byte #(
  parameter int AW = 8
) (
  input  wire logic          sys_clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wdata_in,
  output logic      [7:0]    rdata_out
);
  logic [7:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------
  // byte array, registered read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule

/* File: design/strobe_timer.sv */
`timescale 1ns/1ps
module strobe_timer (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       load_in,
  input  wire logic [4:0] len_in,
  output logic            last_out
);
  logic [4:0] cnt_q;

  // ----------------------------------------------------------------
  // down counter, last flags the final strobe cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 5'h00;
    end
    else if (load_in)
    begin
      cnt_q <= len_in;
    end
    else if (cnt_q != 5'h00)
    begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  assign last_out = (cnt_q == 5'h01);
endmodule

/* File: design/expanded_data_ram_access.sv */
`timescale 1ns/1ps
// Summary of operation
// - 1024 bytes of on-chip expanded RAM sit at external data 0x000..0x3FF.
// - internal bytes 0x00..0x7F answer both direct and indirect access.
// - upper bytes 0x80..0xFF are indirect only, separate from function space.
// - function registers 0x80..0xFF are reached only by direct access.
// - above 0x7F, direct selects function space, indirect selects upper RAM.
// - select clear: R0/R1/pointer moves hit on-chip RAM, pins stay idle.
// - select clear: pointer moves beyond visible size run an external cycle.
// - on-chip bytes above 0xFF reachable only by pointer moves.
// - select set: register move drives eight-bit address on port 0 only.
// - select set: pointer move puts high byte on port 2, low on port 0.
// - every external move pulses read strobe or write strobe.
// - stack accesses use only the 256-byte internal RAM.
// - strobes last 6 clocks, or 30 clocks with stretch set.
// - size field 01 shows 512 bytes, 10 shows 768; rest goes external.
// - bit 1 picks on-chip RAM when clear, external memory when set.
// - latch strobe free-runs at 1/6 (1/3 double speed) unless control set.
// - bit 7 set disables the weak pull-ups on standard ports.
// - register resets to 0X0X1100 and is not bit addressable.
module expanded_data_ram_access (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        xmove_req_in,
  input  wire logic        xmove_wr_in,
  input  wire logic        xmove_data_pointer_in,
  input  wire logic [15:0] xmove_addr_in,
  input  wire logic [7:0]  xmove_wdata_in,
  output logic             xmove_busy_out,
  output logic             xmove_done_out,
  output logic      [7:0]  xmove_rdata_out,
  input  wire logic        idata_req_in,
  input  wire logic        idata_wr_in,
  input  wire logic        idata_indirect_in,
  input  wire logic        idata_stack_in,
  input  wire logic [7:0]  idata_addr_in,
  input  wire logic [7:0]  idata_wdata_in,
  output logic             idata_done_out,
  output logic      [7:0]  idata_rdata_out,
  output logic             sfr_req_out,
  output logic             sfr_wr_out,
  output logic      [7:0]  sfr_addr_out,
  output logic      [7:0]  sfr_wdata_out,
  input  wire logic [7:0]  sfr_rdata_in,
  input  wire logic        code_read_in,
  input  wire logic        double_speed_in,
  input  wire logic [7:0]  p0_in,
  output logic      [7:0]  p0_out,
  output logic             p0_oe_out,
  output logic      [7:0]  p2_out,
  output logic             p2_oe_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic             ale_out,
  output logic             pullup_disable_out
);
  typedef enum logic [2:0] {X_IDLE, X_EXPANDED_RAM, X_ADDR, X_HOLD, X_STROBE, X_END} xstate_t;

  xstate_t    state_q;
  logic [7:0] aux_q;
  logic [15:0] x_addr_q;
  logic [7:0] x_wd_q;
  logic       x_wr_q;
  logic       x_data_pointer_q;
  logic       x_expanded_ram_q;
  logic [7:0] x_rd_q;
  logic       x_done_q;
  logic [7:0] p0_q;
  logic       p0_oe_q;
  logic [7:0] p2_q;
  logic       p2_oe_q;
  logic       rd_n_q;
  logic       wr_n_q;
  logic       ale_q;
  logic [2:0] ale_cnt_q;
  logic [15:0] expanded_ram_limit;
  logic       to_expanded_ram;
  logic       strobe_last;
  logic [7:0] expanded_ram_q;
  logic       id_st1_q;
  logic       id_st2_q;
  logic [7:0] id_addr_q;
  logic [7:0] id_wd_q;
  logic       id_wr_q;
  expanded_ram_pkg::idata_sel_t id_sel_q;
  expanded_ram_pkg::idata_sel_t id_sel;
  logic [7:0] iram_q;
  logic [7:0] id_rd_q;
  logic       id_done_q;
  logic       sfr_req_q;
  logic       busy_q;

  // ----------------------------------------------------------------
  // visible expanded RAM size and target decode
  // ----------------------------------------------------------------
  always_comb
  begin
    case ({aux_q[expanded_ram_pkg::SIZE_HI_BIT], aux_q[expanded_ram_pkg::SIZE_LO_BIT]})
      2'b00:   expanded_ram_limit = expanded_ram_pkg::EXPANDED_RAM_256;
      2'b01:   expanded_ram_limit = expanded_ram_pkg::EXPANDED_RAM_512;
      2'b10:   expanded_ram_limit = expanded_ram_pkg::EXPANDED_RAM_768;
      default: expanded_ram_limit = expanded_ram_pkg::EXPANDED_RAM_1024;
    endcase
    // register moves carry 8 bits so only pointer moves pass 0xFF
    to_expanded_ram = !aux_q[expanded_ram_pkg::EXTSEL_BIT]
      && (!xmove_data_pointer_in || (xmove_addr_in < expanded_ram_limit));
  end

  // ----------------------------------------------------------------
  // auxiliary register, byte-wide only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      aux_q <= expanded_ram_pkg::AUX_RESET;
    end
    else if (id_st1_q && id_wr_q && (id_sel_q == expanded_ram_pkg::SEL_AUX))
    begin
      // reserved bits stay zero whatever is written
      aux_q <= id_wd_q & expanded_ram_pkg::AUX_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // external data move sequencer
  // ----------------------------------------------------------------
  strobe_timer u_strobe (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .load_in    (state_q == X_HOLD),
    .len_in     (aux_q[expanded_ram_pkg::STRETCH_BIT] ? expanded_ram_pkg::STROBE_LONG
                                              : expanded_ram_pkg::STROBE_SHORT),
    .last_out   (strobe_last)
  );

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q  <= X_IDLE;
      busy_q   <= 1'b0;
      x_addr_q <= 16'h0000;
      x_wd_q   <= 8'h00;
      x_wr_q   <= 1'b0;
      x_data_pointer_q <= 1'b0;
      x_expanded_ram_q <= 1'b0;
      x_rd_q   <= 8'h00;
      x_done_q <= 1'b0;
      p0_q     <= 8'h00;
      p0_oe_q  <= 1'b0;
      p2_q     <= 8'h00;
      p2_oe_q  <= 1'b0;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
    end
    else
    begin
      x_done_q <= 1'b0;
      case (state_q)
        X_IDLE:
        begin
          if (xmove_req_in)
          begin
            busy_q   <= 1'b1;
            // register moves carry only the low address byte
            x_addr_q <= xmove_data_pointer_in ? xmove_addr_in : {8'h00, xmove_addr_in[7:0]};
            x_wd_q   <= xmove_wdata_in;
            x_wr_q   <= xmove_wr_in;
            x_data_pointer_q <= xmove_data_pointer_in;
            x_expanded_ram_q <= to_expanded_ram;
            if (to_expanded_ram)
            begin
              state_q <= X_EXPANDED_RAM;
            end
            else
            begin
              state_q <= X_ADDR;
              p0_q    <= xmove_addr_in[7:0];
              p0_oe_q <= 1'b1;
              p2_q    <= xmove_addr_in[15:8];
              p2_oe_q <= xmove_data_pointer_in;
            end
          end
        end
        X_EXPANDED_RAM:
        begin
          state_q <= X_END;
        end
        X_ADDR:
        begin
          state_q <= X_HOLD;
        end
        X_HOLD:
        begin
          state_q <= X_STROBE;
          p0_q    <= x_wd_q;
          p0_oe_q <= x_wr_q;
          rd_n_q  <= x_wr_q;
          wr_n_q  <= !x_wr_q;
        end
        X_STROBE:
        begin
          if (strobe_last)
          begin
            state_q <= X_END;
            x_rd_q  <= p0_in;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
          end
        end
        X_END:
        begin
          state_q  <= X_IDLE;
          busy_q   <= 1'b0;
          x_done_q <= 1'b1;
          p0_oe_q  <= 1'b0;
          p2_oe_q  <= 1'b0;
          if (x_expanded_ram_q && !x_wr_q)
          begin
            x_rd_q <= expanded_ram_q;
          end
        end
        default:
        begin
          state_q <= X_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  ram_byte #(
    .AW (expanded_ram_pkg::EXPANDED_RAM_AW)
  ) u_expanded_ram (
    .sys_clk_in (sys_clk_in),
    .we_in      ((state_q == X_EXPANDED_RAM) && x_wr_q),
    .addr_in    (x_addr_q[expanded_ram_pkg::EXPANDED_RAM_AW-1:0]),
    .wdata_in   (x_wd_q),
    .rdata_out  (expanded_ram_q)
  );

  // ----------------------------------------------------------------
  // address latch strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ale_cnt_q <= 3'h0;
      ale_q     <= 1'b0;
    end
    else
    begin
      if ((ale_cnt_q >= (double_speed_in ? expanded_ram_pkg::ALE_DIV_X2 : expanded_ram_pkg::ALE_DIV) - 3'h1))
      begin
        ale_cnt_q <= 3'h0;
      end
      else
      begin
        ale_cnt_q <= ale_cnt_q + 3'h1;
      end
      if (state_q == X_ADDR)
      begin
        ale_q <= 1'b1;
      end
      else if (state_q == X_HOLD || state_q == X_STROBE)
      begin
        ale_q <= 1'b0;
      end
      else if (aux_q[expanded_ram_pkg::LATCH_BIT])
      begin
        ale_q <= code_read_in;
      end
      else
      begin
        ale_q <= (ale_cnt_q == 3'h0);
      end
    end
  end

  // ----------------------------------------------------------------
  // internal data space: lower, upper RAM and function space
  // ----------------------------------------------------------------
  always_comb
  begin
    if (idata_indirect_in || idata_stack_in || (idata_addr_in <= expanded_ram_pkg::LOWER_TOP))
    begin
      id_sel = expanded_ram_pkg::SEL_IRAM;
    end
    else if (idata_addr_in == expanded_ram_pkg::AUX_ADDR)
    begin
      id_sel = expanded_ram_pkg::SEL_AUX;
    end
    else
    begin
      id_sel = expanded_ram_pkg::SEL_SFR;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      id_st1_q  <= 1'b0;
      id_st2_q  <= 1'b0;
      id_addr_q <= 8'h00;
      id_wd_q   <= 8'h00;
      id_wr_q   <= 1'b0;
      id_sel_q  <= expanded_ram_pkg::SEL_IRAM;
      id_rd_q   <= 8'h00;
      id_done_q <= 1'b0;
      sfr_req_q <= 1'b0;
    end
    else
    begin
      id_st1_q  <= idata_req_in;
      id_st2_q  <= id_st1_q;
      id_done_q <= id_st2_q;
      sfr_req_q <= idata_req_in && (id_sel == expanded_ram_pkg::SEL_SFR);
      if (idata_req_in)
      begin
        id_addr_q <= idata_addr_in;
        id_wd_q   <= idata_wdata_in;
        id_wr_q   <= idata_wr_in;
        id_sel_q  <= id_sel;
      end
      if (id_st2_q)
      begin
        case (id_sel_q)
          expanded_ram_pkg::SEL_IRAM: id_rd_q <= iram_q;
          expanded_ram_pkg::SEL_AUX:  id_rd_q <= aux_q;
          default:  id_rd_q <= sfr_rdata_in;
        endcase
      end
    end
  end

  ram_byte #(
    .AW (expanded_ram_pkg::IRAM_AW)
  ) u_iram (
    .sys_clk_in (sys_clk_in),
    .we_in      (id_st1_q && id_wr_q && (id_sel_q == expanded_ram_pkg::SEL_IRAM)),
    .addr_in    (id_addr_q),
    .wdata_in   (id_wd_q),
    .rdata_out  (iram_q)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign xmove_busy_out     = busy_q;
  assign xmove_done_out     = x_done_q;
  assign xmove_rdata_out    = x_rd_q;
  assign idata_done_out     = id_done_q;
  assign idata_rdata_out    = id_rd_q;
  assign sfr_req_out        = sfr_req_q;
  assign sfr_wr_out         = id_wr_q;
  assign sfr_addr_out       = id_addr_q;
  assign sfr_wdata_out      = id_wd_q;
  assign p0_out             = p0_q;
  assign p0_oe_out          = p0_oe_q;
  assign p2_out             = p2_q;
  assign p2_oe_out          = p2_oe_q;
  assign rd_n_out           = rd_n_q;
  assign wr_n_out           = wr_n_q;
  assign ale_out            = ale_q;
  assign pullup_disable_out = aux_q[expanded_ram_pkg::PULLUP_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] low_cnt_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || (rd_n_q && wr_n_q))
    begin
      low_cnt_q <= 6'h00;
    end
    else
    begin
      low_cnt_q <= low_cnt_q + 6'h01;
    end
  end

  chk_strobe_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ($rose(rd_n_q && wr_n_q)) |->
      ($past(low_cnt_q) == (aux_q[expanded_ram_pkg::STRETCH_BIT] ? 6'h1D : 6'h05)))
    else $error("strobe length wrong");
  chk_expanded_ram_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == X_EXPANDED_RAM) |-> ##1 (rd_n_q && wr_n_q && !p0_oe_q && !p2_oe_q)[*2])
    else $error("pins moved on on-chip access");
  chk_ri_route: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (xmove_req_in && !xmove_busy_out && !xmove_data_pointer_in && !aux_q[expanded_ram_pkg::EXTSEL_BIT])
      |-> ##1 (state_q == X_EXPANDED_RAM))
    else $error("register move left on-chip RAM");
  chk_hidden_ext: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (xmove_req_in && !xmove_busy_out && xmove_data_pointer_in && (xmove_addr_in >= expanded_ram_limit))
      |-> ##1 (state_q == X_ADDR) ##1 ale_q)
    else $error("hidden address not external");
  chk_ri_no_p2: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == X_ADDR && !x_data_pointer_q) |-> (!p2_oe_q && p0_oe_q))
    else $error("register move drove port 2");
  chk_data_pointer_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == X_ADDR && x_data_pointer_q) |-> (p2_oe_q && p2_q == x_addr_q[15:8]))
    else $error("pointer high byte missing");
  chk_strobe_kind: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == X_HOLD) |-> ##1 (x_wr_q ? (!wr_n_q && rd_n_q) : (!rd_n_q && wr_n_q)))
    else $error("wrong strobe asserted");
  chk_direct_sfr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (idata_req_in && !idata_indirect_in && !idata_stack_in && idata_addr_in[7]
      && idata_addr_in != expanded_ram_pkg::AUX_ADDR) |-> ##1 (sfr_req_q && !u_iram.we_in))
    else $error("direct upper access missed function space");
  chk_aux_reset: assert property (@(posedge sys_clk_in)
    rst_in |=> (aux_q == expanded_ram_pkg::AUX_RESET))
    else $error("aux register reset value wrong");
endmodule

/* File: dv/ext_mem_model.sv */
`timescale 1ns/1ps
// ------------------------------------------
// external memory on the multiplexed bus
// ------------------------------------------
module ext_mem_model (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] p0_bus_in,
  input  wire logic       p0_oe_in,
  input  wire logic [7:0] p2_bus_in,
  input  wire logic       p2_oe_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       ale_in,
  output logic      [7:0] p0_data_out
);
  logic [7:0]  mem [int];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  rd_val;
  always @(posedge sys_clk_in)
  begin
    if (ale_in && p0_oe_in)
    begin
      addr_q <= {(p2_oe_in ? p2_bus_in : 8'h00), p0_bus_in};
    end
    if (!wr_n_in && p0_oe_in)
    begin
      mem[int'(addr_q)] = p0_bus_in;
    end
    if (!rd_n_in)
    begin
      last_q <= rd_val;
    end
  end
  always @*
  begin
    rd_val = mem.exists(int'(addr_q)) ? mem[int'(addr_q)] : addr_q[7:0] ^ addr_q[15:8] ^ 8'h5A;
    // released bus shows the inverse, never stale data
    p0_data_out = rd_n_in ? ~last_q : rd_val;
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ------------------------------------------
// bench with reference model
// ------------------------------------------
module tb;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        xmove_req_in = 1'b0, xmove_wr_in = 1'b0, xmove_data_pointer_in = 1'b0;
  logic [15:0] xmove_addr_in = 16'h0000;
  logic [7:0]  xmove_wdata_in = 8'h00, idata_addr_in = 8'h00, idata_wdata_in = 8'h00;
  logic        idata_req_in = 1'b0, idata_wr_in = 1'b0, idata_indirect_in = 1'b0;
  logic        idata_stack_in = 1'b0, code_read_in = 1'b0, double_speed_in = 1'b0;
  logic [7:0]  sfr_rdata_in = 8'h00, p0_in;
  logic        xmove_busy_out, xmove_done_out, idata_done_out, sfr_req_out, sfr_wr_out;
  logic        p0_oe_out, p2_oe_out, rd_n_out, wr_n_out, ale_out, pullup_disable_out;
  logic [7:0]  xmove_rdata_out, idata_rdata_out, sfr_addr_out, sfr_wdata_out, p0_out, p2_out;
  int          miscompares = 0, compares = 0, cycles = 0, seed = 41194, c;
  int          strobes, ale_hits, oe_hits, sfr_hits;
  logic [7:0]  expanded_ram [1024], iram [256], ext [int], got, a_lo, a_hi, aux_m, v, s_a, s_d;
  logic        a_p2, s_w;
  always #4 sys_clk_in = ~sys_clk_in;
  expanded_data_ram_access u_dut (.sys_clk_in, .rst_in, .xmove_req_in, .xmove_wr_in,
    .xmove_data_pointer_in, .xmove_addr_in, .xmove_wdata_in, .xmove_busy_out, .xmove_done_out,
    .xmove_rdata_out, .idata_req_in, .idata_wr_in, .idata_indirect_in, .idata_stack_in,
    .idata_addr_in, .idata_wdata_in, .idata_done_out, .idata_rdata_out, .sfr_req_out,
    .sfr_wr_out, .sfr_addr_out, .sfr_wdata_out, .sfr_rdata_in, .code_read_in,
    .double_speed_in, .p0_in, .p0_out, .p0_oe_out, .p2_out, .p2_oe_out, .rd_n_out,
    .wr_n_out, .ale_out, .pullup_disable_out);
  ext_mem_model u_mem (.sys_clk_in, .p0_bus_in(p0_out), .p0_oe_in(p0_oe_out),
    .p2_bus_in(p2_out), .p2_oe_in(p2_oe_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .ale_in(ale_out), .p0_data_out(p0_in));
  task automatic summarize();
    if (miscompares == 0 && compares > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  // pin activity seen in the settled half of each cycle
  always @(negedge sys_clk_in)
  begin
    strobes += int'(rd_n_out === 1'b0 || wr_n_out === 1'b0);
    sfr_hits += int'(sfr_req_out === 1'b1);
    ale_hits += int'(ale_out === 1'b1);
    oe_hits += int'(p0_oe_out === 1'b1);
    if (ale_out === 1'b1 && p0_oe_out === 1'b1)
    begin
      a_lo = p0_out;
      a_hi = p2_out;
      a_p2 = p2_oe_out;
    end
    if (sfr_req_out === 1'b1)
    begin
      s_a = sfr_addr_out;
      s_d = sfr_wdata_out;
      s_w = sfr_wr_out;
    end
  end
  task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
    compares++;
    if (act !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask
  task automatic icheck(input logic wr, input logic ind, input logic stk,
                        input logic [7:0] a, input logic [7:0] d);
    int n;
    logic special_function_space;
    special_function_space = a > 8'h7F && !ind && !stk;
    sfr_hits = 0;
    s_a = ~a;
    @(posedge sys_clk_in);
    idata_req_in <= 1'b1;
    idata_wr_in <= wr;
    idata_indirect_in <= ind;
    idata_stack_in <= stk;
    idata_addr_in <= a;
    idata_wdata_in <= d;
    @(posedge sys_clk_in);
    idata_req_in <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk_in);
      n++;
    end while (idata_done_out !== 1'b1 && n < 20);
    got = idata_rdata_out;
    if (special_function_space && a == 8'h8E)
    begin
      if (wr)
        aux_m = d;
      else
        check(got, aux_m, "aux read");
    end
    else if (special_function_space)
    begin
      check(8'(sfr_hits), 8'h01, "function access");
      check(s_a, a, "function address");
      check({7'h00, s_w}, {7'h00, wr}, "function direction");
      if (wr)
        check(s_d, d, "function write data");
      else
        check(got, sfr_rdata_in, "function data");
    end
    else
    begin
      check(8'(sfr_hits), 8'h00, "ram routed away");
      if (wr)
        iram[a] = d;
      else
        check(got, iram[a], "ram data");
    end
  endtask
  task automatic xcheck(input logic wr, input logic dp, input logic [15:0] a);
    int n;
    logic [7:0] d;
    logic [9:0] idx;
    logic [15:0] key;
    d = 8'($random(seed));
    idx = dp ? a[9:0] : {2'h0, a[7:0]};
    key = dp ? a : {8'h00, a[7:0]};
    strobes = 0;
    oe_hits = 0;
    a_p2 = 1'b0;
    a_lo = 8'h00;
    @(posedge sys_clk_in);
    xmove_req_in <= 1'b1;
    xmove_wr_in <= wr;
    xmove_data_pointer_in <= dp;
    xmove_addr_in <= a;
    xmove_wdata_in <= d;
    @(posedge sys_clk_in);
    xmove_req_in <= 1'b0;
    @(negedge sys_clk_in);
    check({7'h00, xmove_busy_out}, 8'h01, "busy after request");
    n = 1;
    while (xmove_done_out !== 1'b1 && n < 60)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    got = xmove_rdata_out;
    check({7'h00, xmove_done_out}, 8'h01, "move done");
    check({7'h00, xmove_busy_out}, 8'h00, "busy at done");
    if (!aux_m[1] && (!dp || int'(a) < 256 * (int'(aux_m[3:2]) + 1)))
    begin
      check(8'(strobes + oe_hits), 8'h00, "pins moved");
      if (wr)
        expanded_ram[idx] = d;
      else
        check(got, expanded_ram[idx], "on-chip data");
    end
    else
    begin
      check(8'(strobes), aux_m[5] ? 8'h1E : 8'h06, "strobe length");
      check(a_lo, a[7:0], "low address");
      check({7'h00, a_p2}, {7'h00, dp}, "port 2 drive");
      if (dp)
        check(a_hi, a[15:8], "high address");
      if (wr)
        ext[int'(key)] = d;
      else
        check(got, ext.exists(int'(key)) ? ext[int'(key)] : key[7:0] ^ key[15:8] ^ 8'h5A,
              "bus data");
    end
  endtask
  task automatic ale_count(input logic [7:0] exp);
    repeat (6) @(posedge sys_clk_in);
    ale_hits = 0;
    repeat (60) @(posedge sys_clk_in);
    check(8'(ale_hits), exp, "latch strobe count");
  endtask
  initial
  begin
    aux_m = expanded_ram_pkg::AUX_RESET;
    sfr_rdata_in <= 8'($random(seed));
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    check({rd_n_out, wr_n_out, p0_oe_out, pullup_disable_out}, 8'h0C, "idle pins");
    icheck(1'b0, 1'b0, 1'b0, 8'h8E, 8'h00);
    icheck(1'b1, 1'b0, 1'b0, 8'h10, 8'($random(seed)));
    icheck(1'b0, 1'b1, 1'b0, 8'h10, 8'h00);
    icheck(1'b1, 1'b1, 1'b0, 8'h90, 8'($random(seed)));
    icheck(1'b0, 1'b0, 1'b0, 8'h90, 8'h00);
    icheck(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
    icheck(1'b1, 1'b0, 1'b1, 8'hA0, 8'($random(seed)));
    icheck(1'b1, 1'b0, 1'b0, 8'hA0, 8'($random(seed)));
    icheck(1'b0, 1'b1, 1'b0, 8'hA0, 8'h00);
    xcheck(1'b1, 1'b0, 16'hFFA0);
    xcheck(1'b0, 1'b1, 16'h00A0);
    xcheck(1'b1, 1'b1, 16'h03FF);
    xcheck(1'b0, 1'b1, 16'h03FF);
    for (c = 0; c < 4; c++)
    begin
      icheck(1'b1, 1'b0, 1'b0, 8'h8E, 8'(c * 4));
      xcheck(1'b1, 1'b1, 16'(256 * (c + 1) - 1));
      xcheck(1'b0, 1'b1, 16'(256 * (c + 1) - 1));
      xcheck(1'b0, 1'b1, 16'(256 * (c + 1)));
      xcheck(1'b1, 1'b0, 16'h00FF);
    end
    icheck(1'b1, 1'b0, 1'b0, 8'h8E, 8'h02);
    xcheck(1'b1, 1'b0, 16'h0033);
    xcheck(1'b0, 1'b0, 16'h0033);
    xcheck(1'b0, 1'b1, 16'h0005);
    icheck(1'b1, 1'b0, 1'b0, 8'h8E, 8'h22);
    xcheck(1'b1, 1'b1, 16'h1234);
    xcheck(1'b0, 1'b1, 16'h1234);
    for (c = 0; c < 4; c++)
    begin
      v = 8'($random(seed)) & 8'hAC;
      icheck(1'b1, 1'b0, 1'b0, 8'h8E, v);
      icheck(1'b0, 1'b0, 1'b0, 8'h8E, 8'h00);
      check({7'h00, pullup_disable_out}, {7'h00, v[7]}, "pull-up control");
    end
    icheck(1'b1, 1'b0, 1'b0, 8'h8E, 8'h00);
    ale_count(8'h0A);
    double_speed_in <= 1'b1;
    ale_count(8'h14);
    icheck(1'b1, 1'b0, 1'b0, 8'h8E, 8'h01);
    ale_count(8'h00);
    @(posedge sys_clk_in);
    code_read_in <= 1'b1;
    ale_hits = 0;
    @(posedge sys_clk_in);
    code_read_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check(8'(ale_hits > 0), 8'h01, "code read latch strobe");
    summarize();
  end
endmodule
